// ### logic/dma_pkg.sv
// Constants, encodings and types shared by the DMA register and counter core
package dma_pkg;
  localparam int BYTE_W      = 8;
  localparam int ADDR_W      = 16;
  localparam int SYNC_STAGES = 3;
  localparam int RD_REGS     = 7;

  // Base byte layout: group code, pointer bits, one control bit
  localparam int GRP_LSB  = 0;
  localparam int GRP_W    = 3;
  localparam int PTR_LSB  = 3;
  localparam int PTR_W    = 4;
  localparam int CTRL_BIT = 7;
  localparam int CMD_LSB  = 4;
  localparam int CMD_W    = 4;

  // Group codes
  localparam logic [2:0] GRP_PORT_A_AND_LENGTH = 3'h0;
  localparam logic [2:0] GRP_PORT_A_CFG        = 3'h1;
  localparam logic [2:0] GRP_PORT_B_CFG        = 3'h2;
  localparam logic [2:0] GRP_MODE              = 3'h3;
  localparam logic [2:0] GRP_PORT_B_AND_PULSE  = 3'h4;
  localparam logic [2:0] GRP_PULSE_CTRL        = 3'h5;
  localparam logic [2:0] GRP_COMMAND_AND_MASK  = 3'h6;

  // Port config byte fields
  localparam int CFG_STEP_LSB = 0;
  localparam int CFG_VAR2_BIT = 2;

  // Mode byte fields
  localparam int MB_MODE_LSB   = 0;
  localparam int MB_CLASS_LSB  = 2;
  localparam int MB_STOP_MATCH = 4;
  localparam int MB_STOP_END   = 5;
  localparam int MB_AUTO       = 6;
  localparam int MB_RDY_HIGH   = 7;

  // Status byte fields
  localparam int STS_OWNED   = 0;
  localparam int STS_READY   = 1;
  localparam int STS_END     = 2;
  localparam int STS_MATCH   = 3;
  localparam int STS_ENABLED = 4;

  // Reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h01;
  localparam logic [7:0] RST_MODE     = 8'ha1;
  localparam logic [6:0] RST_RD_MASK  = 7'h7f;
  localparam logic [2:0] SYNC_RST     = 3'b011;

  localparam logic [1:0] STEP_DEC = 2'h0;
  localparam logic [1:0] STEP_INC = 2'h1;
  localparam logic [1:0] STEP_FIX = 2'h2;

  typedef enum logic [1:0] {
    MODE_BYTE  = 2'h0,
    MODE_BURST = 2'h1,
    MODE_CONT  = 2'h2
  } xfer_mode_t;

  typedef enum logic [1:0] {
    CLS_TRANSFER = 2'h0,
    CLS_SEARCH   = 2'h1,
    CLS_SIMUL    = 2'h2
  } op_class_t;

  typedef enum logic [3:0] {
    CMD_NONE        = 4'h0,
    CMD_LOAD        = 4'h1,
    CMD_ENABLE      = 4'h2,
    CMD_DISABLE     = 4'h3,
    CMD_FORCE_READY = 4'h4,
    CMD_CONTINUE    = 4'h5,
    CMD_INIT_READ   = 4'h6,
    CMD_READ_STATUS = 4'h7
  } cmd_t;

  typedef enum logic [2:0] {
    S_IDLE       = 3'h0,
    S_WAIT_GRANT = 3'h1,
    S_SETUP      = 3'h2,
    S_READ       = 3'h3,
    S_WRITE      = 3'h4
  } state_t;
endpackage

// ### logic/dma_pair_buffer.sv
// Small FIFO holding read bytes until their write cycle
`timescale 1ns/1ps
module dma_pair_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ### logic/dma_register_counter_core.sv
// Register file, counters and transfer sequencer of a two-port DMA channel
`timescale 1ns/1ps
module dma_register_counter_core
  import dma_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Host byte port
  input  wire logic              host_wr_valid,
  input  wire logic [BYTE_W-1:0] host_wr_data,
  input  wire logic              host_rd_req,
  output logic      [BYTE_W-1:0] host_rd_data,
  output logic                   host_rd_valid,
  // Pins
  input  wire logic              rdy_in,
  input  wire logic              bus_request_line_n_in,
  output logic                   bus_request_line_n_out,
  output logic                   bus_request_line_n_oe,
  input  wire logic              bus_grant_line_n_in,
  output logic                   interrupt_or_pulse_output_n_out,
  output logic                   interrupt_or_pulse_output_n_oe,
  // Transfer cycle port
  output logic                   cyc_valid,
  output logic                   cyc_write,
  output logic      [ADDR_W-1:0] cyc_addr,
  output logic      [BYTE_W-1:0] cyc_wdata,
  input  wire logic              cyc_done,
  input  wire logic [BYTE_W-1:0] cyc_rdata,
  // Status
  output logic                   enabled,
  output logic                   end_found,
  output logic                   match_found
);
  // Write registers
  logic [ADDR_W-1:0] start_a;
  logic [ADDR_W-1:0] start_b;
  logic [ADDR_W-1:0] length;
  logic              a_is_source;
  logic [7:0]        cfg_a;
  logic [7:0]        cfg_b;
  logic [7:0]        mode_byte;
  logic [7:0]        match_byte;
  logic [7:0]        match_mask;
  logic [7:0]        pulse_offset;
  logic              pulse_en;
  logic [6:0]        rd_mask;
  logic [PTR_W-1:0]  pend;
  logic [GRP_W-1:0]  pend_grp;
  // Counters and engine
  logic [ADDR_W-1:0] addr_a;
  logic [ADDR_W-1:0] addr_b;
  logic [ADDR_W-1:0] byte_cnt;
  state_t            state;
  state_t            next_state;
  logic              force_ready;
  logic              byte_done;
  logic              match_armed;
  logic              extra_pend;
  logic [2:0]        rd_ptr;
  logic              status_once;
  logic              pulse;
  // Synchronised pins
  logic [2:0]        pin_raw;
  logic [2:0]        pin_f;

  assign pin_raw = {rdy_in, bus_request_line_n_in, bus_grant_line_n_in};

  for (genvar g = 0; g < 3; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] sh;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sh       <= {SYNC_STAGES{SYNC_RST[g]}};
        pin_f[g] <= SYNC_RST[g];
      end else begin
        sh <= {sh[SYNC_STAGES-2:0], pin_raw[g]};
        if (sh[1] == sh[2]) begin
          pin_f[g] <= sh[2];
        end
      end
    end
  end

  // Decoded fields
  xfer_mode_t        xmode;
  op_class_t         cls;
  logic              is_xfer;
  logic              bus_req;
  logic              owned;
  logic              other_req;
  logic              ready_act;
  logic              base_wr;
  logic              data_wr;
  logic [1:0]        ptr_idx;
  cmd_t              cmd;
  logic              rd_done;
  logic              wr_done;
  logic              rd_hit;
  logic              at_end;
  logic              src_var2;
  logic              end_evt;
  logic              match_evt;
  logic              match_early;
  logic              finish;
  logic              restart;
  logic              go_write;
  logic              count_step;
  logic [ADDR_W-1:0] src_cnt;
  logic [ADDR_W-1:0] dst_cnt;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [BYTE_W:0]   buf_out;
  logic [BYTE_W-1:0] status_byte;

  assign xmode     = xfer_mode_t'(mode_byte[MB_MODE_LSB +: 2]);
  assign cls       = op_class_t'(mode_byte[MB_CLASS_LSB +: 2]);
  assign is_xfer   = (cls == CLS_TRANSFER);
  assign bus_req   = (state != S_IDLE);
  assign owned     = bus_req && !pin_f[0];
  assign other_req = !pin_f[1] && !bus_req;
  assign ready_act = (pin_f[2] == mode_byte[MB_RDY_HIGH]) || force_ready;
  assign base_wr   = host_wr_valid && (pend == '0);
  assign data_wr   = host_wr_valid && (pend != '0);
  assign cmd       = (base_wr && host_wr_data[GRP_LSB +: GRP_W] ==
                      GRP_COMMAND_AND_MASK) ?
                     cmd_t'(host_wr_data[CMD_LSB +: CMD_W]) : CMD_NONE;
  assign rd_done   = (state == S_READ) && cyc_done;
  assign wr_done   = (state == S_WRITE) && cyc_done;
  assign rd_hit    = ((cyc_rdata ^ match_byte) & ~match_mask) == '0;
  assign at_end    = (byte_cnt == length);
  assign src_var2  = a_is_source ? cfg_a[CFG_VAR2_BIT] : cfg_b[CFG_VAR2_BIT];
  assign src_cnt   = a_is_source ? addr_a : addr_b;
  assign dst_cnt   = a_is_source ? addr_b : addr_a;
  assign go_write  = is_xfer && !buf_in_ready;

  // Lowest set pointer bit picks the register written next
  always_comb begin
    ptr_idx = '0;
    for (int i = PTR_W - 1; i >= 0; i--) begin
      if (pend[i]) begin
        ptr_idx = 2'(i);
      end
    end
  end

  // Stop decisions
  always_comb begin
    end_evt   = 1'b0;
    match_evt = 1'b0;
    if (is_xfer) begin
      end_evt   = wr_done && at_end && mode_byte[MB_STOP_END];
      match_evt = wr_done && buf_out[BYTE_W] &&
                  mode_byte[MB_STOP_MATCH];
    end else begin
      end_evt   = rd_done && (extra_pend ||
                  (at_end && mode_byte[MB_STOP_END] &&
                   !(cls == CLS_SIMUL && src_var2 && ready_act)));
      match_evt = rd_done && match_armed;
    end
  end

  assign match_early = (state == S_SETUP) && match_armed && !is_xfer &&
                       (xmode != MODE_BYTE) && !ready_act;
  assign finish      = end_evt || match_evt || match_early;
  assign restart     = end_evt && mode_byte[MB_AUTO];
  assign count_step  = (is_xfer ? wr_done : rd_done) &&
                       !(at_end && mode_byte[MB_STOP_END]);

  dma_pair_buffer #(
    .WIDTH (BYTE_W + 1),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (finish || cmd == CMD_LOAD),
    .in_valid  (rd_done && is_xfer),
    .in_data   ({rd_hit, cyc_rdata}),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out),
    .out_ready (wr_done)
  );

  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                             input logic [1:0] m);
    case (m)
      STEP_INC: step = a + ADDR_W'(1);
      STEP_DEC: step = a - ADDR_W'(1);
      default:  step = a;
    endcase
  endfunction

  // Next enabled read register after cur, wrapping round
  function automatic logic [2:0] next_sel(input logic [2:0] cur,
                                          input logic [6:0] m);
    logic [2:0] r;
    logic [2:0] c;
    r = cur;
    c = cur;
    for (int i = RD_REGS; i >= 1; i--) begin
      c = 3'((int'(cur) + i) % RD_REGS);
      if (m[c]) begin
        r = c;
      end
    end
    return r;
  endfunction

  // Grouped write registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_a      <= '0;
      start_b      <= '0;
      length       <= '0;
      a_is_source  <= 1'b1;
      cfg_a        <= RST_PORT_CFG;
      cfg_b        <= RST_PORT_CFG;
      mode_byte    <= RST_MODE;
      match_byte   <= '0;
      match_mask   <= '0;
      pulse_offset <= '0;
      pulse_en     <= 1'b0;
      rd_mask      <= RST_RD_MASK;
      pend         <= '0;
      pend_grp     <= '0;
    end else if (base_wr) begin
      pend_grp <= host_wr_data[GRP_LSB +: GRP_W];
      pend     <= host_wr_data[PTR_LSB +: PTR_W];
      case (host_wr_data[GRP_LSB +: GRP_W])
        GRP_PORT_A_AND_LENGTH: a_is_source <= host_wr_data[CTRL_BIT];
        GRP_PULSE_CTRL:        pulse_en    <= host_wr_data[CTRL_BIT];
        GRP_COMMAND_AND_MASK:  pend <= {3'h0, host_wr_data[PTR_LSB]};
        default: ;
      endcase
    end else if (data_wr) begin
      pend[ptr_idx] <= 1'b0;
      case (pend_grp)
        GRP_PORT_A_AND_LENGTH: begin
          case (ptr_idx)
            2'h0:    start_a[7:0]  <= host_wr_data;
            2'h1:    start_a[15:8] <= host_wr_data;
            2'h2:    length[7:0]   <= host_wr_data;
            default: length[15:8]  <= host_wr_data;
          endcase
        end
        GRP_PORT_A_CFG: cfg_a <= host_wr_data;
        GRP_PORT_B_CFG: cfg_b <= host_wr_data;
        GRP_MODE: begin
          case (ptr_idx)
            2'h0:    mode_byte  <= host_wr_data;
            2'h1:    match_byte <= host_wr_data;
            default: match_mask <= host_wr_data;
          endcase
        end
        GRP_PORT_B_AND_PULSE: begin
          case (ptr_idx)
            2'h0:    start_b[7:0]  <= host_wr_data;
            2'h1:    start_b[15:8] <= host_wr_data;
            default: pulse_offset  <= host_wr_data;
          endcase
        end
        GRP_COMMAND_AND_MASK: rd_mask <= host_wr_data[6:0];
        default: ;
      endcase
    end
  end

  // Counters: address counters loaded only from start registers, byte counter cleared; never written by host
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_a   <= '0;
      addr_b   <= '0;
      byte_cnt <= '0;
    end else if (cmd == CMD_LOAD || restart) begin
      addr_a   <= start_a;
      addr_b   <= start_b;
      byte_cnt <= '0;
    end else if (cmd == CMD_CONTINUE) begin
      byte_cnt <= '0;
    end else begin
      if (rd_done) begin
        if (a_is_source) begin
          addr_a <= step(addr_a, cfg_a[CFG_STEP_LSB +: 2]);
        end else begin
          addr_b <= step(addr_b, cfg_b[CFG_STEP_LSB +: 2]);
        end
      end
      if (wr_done) begin
        if (a_is_source) begin
          addr_b <= step(addr_b, cfg_b[CFG_STEP_LSB +: 2]);
        end else begin
          addr_a <= step(addr_a, cfg_a[CFG_STEP_LSB +: 2]);
        end
      end
      if (count_step) begin
        byte_cnt <= byte_cnt + ADDR_W'(1);
      end
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (enabled && ready_act && !other_req) begin
          next_state = S_WAIT_GRANT;
        end
      end
      S_WAIT_GRANT: begin
        if (!enabled) begin
          next_state = S_IDLE;
        end else if (owned) begin
          next_state = S_SETUP;
        end
      end
      S_SETUP: begin
        if (!enabled || match_early) begin
          next_state = S_IDLE;
        end else if (xmode == MODE_BYTE && byte_done) begin
          next_state = S_IDLE;
        end else if (!ready_act) begin
          next_state = (xmode == MODE_CONT) ? S_SETUP : S_IDLE;
        end else begin
          next_state = go_write ? S_WRITE : S_READ;
        end
      end
      S_READ, S_WRITE: begin
        if (cyc_done) begin
          next_state = (finish && !restart) ? S_IDLE : S_SETUP;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cycle address and data latched before each bus cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_write <= 1'b0;
      cyc_addr  <= '0;
      cyc_wdata <= '0;
    end else if (state == S_SETUP) begin
      cyc_write <= go_write;
      cyc_addr  <= go_write ? dst_cnt : src_cnt;
      cyc_wdata <= buf_out[BYTE_W-1:0];
    end
  end

  assign cyc_valid = (state == S_READ) || (state == S_WRITE);

  // Engine flags; a clear in the same cycle as a set wins, except for force_ready, end_found and match_found
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enabled     <= 1'b0;
      force_ready <= 1'b0;
      end_found   <= 1'b0;
      match_found <= 1'b0;
      byte_done   <= 1'b0;
      match_armed <= 1'b0;
      extra_pend  <= 1'b0;
    end else begin
      if (cmd == CMD_ENABLE) begin
        enabled <= 1'b1;
      end
      if (cmd == CMD_DISABLE || (finish && !restart)) begin
        enabled <= 1'b0;
      end
      if (cmd == CMD_FORCE_READY) begin
        force_ready <= 1'b1;
      end else if (cmd == CMD_DISABLE) begin
        force_ready <= 1'b0;
      end
      if (cmd == CMD_LOAD || cmd == CMD_ENABLE) begin
        end_found   <= 1'b0;
        match_found <= 1'b0;
      end
      if (end_evt) begin
        end_found <= 1'b1;
      end
      if (match_evt || match_early) begin
        match_found <= 1'b1;
      end
      if (state == S_WAIT_GRANT) begin
        byte_done <= 1'b0;
      end else if (is_xfer ? wr_done : rd_done) begin
        byte_done <= 1'b1;
      end
      if (finish || cmd == CMD_LOAD) begin
        match_armed <= 1'b0;
        extra_pend  <= 1'b0;
      end else if (rd_done && !is_xfer) begin
        if (rd_hit && mode_byte[MB_STOP_MATCH]) begin
          match_armed <= 1'b1;
        end
        if (at_end && mode_byte[MB_STOP_END] && cls == CLS_SIMUL &&
            src_var2 && ready_act) begin
          extra_pend <= 1'b1;
        end
      end
    end
  end

  // Periodic pulse on byte counter low byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse <= 1'b0;
    end else begin
      pulse <= owned && pulse_en && count_step &&
               (byte_cnt[7:0] + 8'h01 == pulse_offset);
    end
  end

  assign interrupt_or_pulse_output_n_out = 1'b0;
  assign interrupt_or_pulse_output_n_oe  = pulse;
  assign bus_request_line_n_out          = 1'b0;
  assign bus_request_line_n_oe           = bus_req;

  assign status_byte = {3'h0, enabled, match_found, end_found, ready_act,
                        owned};

  // Host reads: masked sequence, or status alone after its command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr        <= '0;
      status_once   <= 1'b0;
      host_rd_data  <= '0;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_rd_req;
      if (cmd == CMD_INIT_READ) begin
        rd_ptr <= next_sel(3'(RD_REGS - 1), rd_mask);
      end
      if (cmd == CMD_READ_STATUS) begin
        status_once <= 1'b1;
      end
      if (host_rd_req) begin
        if (status_once) begin
          host_rd_data <= status_byte;
          status_once  <= 1'b0;
        end else begin
          rd_ptr <= next_sel(rd_ptr, rd_mask);
          case (rd_ptr)
            3'h0:    host_rd_data <= status_byte;
            3'h1:    host_rd_data <= byte_cnt[7:0];
            3'h2:    host_rd_data <= byte_cnt[15:8];
            3'h3:    host_rd_data <= addr_a[7:0];
            3'h4:    host_rd_data <= addr_a[15:8];
            3'h5:    host_rd_data <= addr_b[7:0];
            default: host_rd_data <= addr_b[15:8];
          endcase
        end
      end
    end
  end
endmodule

// ### bench/dma_core_asserts.sv
// Port checks for the DMA register and counter core
`timescale 1ns/1ps
module dma_core_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        host_rd_req,
  input wire logic        host_rd_valid,
  input wire logic        enabled,
  input wire logic        end_found,
  input wire logic        bus_request_line_n_oe,
  input wire logic        interrupt_or_pulse_output_n_oe,
  input wire logic        cyc_valid,
  input wire logic        cyc_done,
  input wire logic        cyc_write,
  input wire logic [15:0] cyc_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (host_rd_req |=> host_rd_valid)
    else $error("read request not answered");
  rd_quiet_a: assert property (!host_rd_req |=> !host_rd_valid)
    else $error("read answer without request");
  pulse_owned_a: assert property (interrupt_or_pulse_output_n_oe |->
    $past(bus_request_line_n_oe)) else $error("pulse while bus not owned");
  pulse_one_a: assert property (interrupt_or_pulse_output_n_oe |=>
    !interrupt_or_pulse_output_n_oe) else $error("pulse too long");
  cyc_hold_a: assert property (cyc_valid && !cyc_done |=> cyc_valid &&
    $stable(cyc_addr) && $stable(cyc_write)) else $error("cycle changed");
  cyc_owned_a: assert property (cyc_valid |-> bus_request_line_n_oe)
    else $error("cycle without bus request");
  req_enable_a: assert property ($rose(bus_request_line_n_oe) |->
    $past(enabled)) else $error("request while disabled");
  idle_stay_a: assert property (!enabled && !bus_request_line_n_oe |=>
    !bus_request_line_n_oe) else $error("request left idle");
  cover property (interrupt_or_pulse_output_n_oe);
  cover property ($rose(end_found));
  cover property (cyc_valid && cyc_write && cyc_done);
endmodule

bind dma_register_counter_core dma_core_asserts chk (.clk, .rst_n,
  .host_rd_req, .host_rd_valid, .enabled, .end_found, .bus_request_line_n_oe,
  .interrupt_or_pulse_output_n_oe, .cyc_valid, .cyc_done, .cyc_write,
  .cyc_addr);

// ### bench/dma_mem_model.sv
// Memory and bus grant model on the far side of the DMA core
`timescale 1ns/1ps
module dma_mem_model #(
  parameter int DLY = 2
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req_oe,
  input  wire logic        cyc_valid,
  input  wire logic [15:0] cyc_addr,
  output logic             grant_n,
  output logic             cyc_done,
  output logic [7:0]       cyc_rdata
);
  logic [3:0] gd;
  int         wait_n;
  // Released data lines show the inverse, never a stale byte
  assign cyc_rdata = cyc_done ? cyc_addr[7:0] : ~cyc_addr[7:0];
  assign grant_n = gd[3];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gd <= 4'hf;
      wait_n <= 0;
      cyc_done <= 1'b0;
    end else begin
      gd <= {gd[2:0], ~req_oe};
      cyc_done <= cyc_valid && !cyc_done && wait_n == DLY;
      wait_n <= (cyc_valid && !cyc_done) ? wait_n + 1 : 0;
    end
  end
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the DMA register and counter core
`timescale 1ns/1ps
module tb_top;
  import dma_pkg::*;
  logic        clk, rst_n, host_wr_valid, host_rd_req, host_rd_valid;
  logic [7:0]  host_wr_data, host_rd_data, cyc_wdata, cyc_rdata, d;
  logic        grant_n, req_oe, pulse, cyc_valid, cyc_write, cyc_done;
  logic        end_found, match_found, enabled, rdy;
  logic [15:0] cyc_addr;
  logic [23:0] wq[$];
  int          bad_count, checks, pulses, cyc_n;
  dma_register_counter_core dut (.clk, .rst_n, .host_wr_valid,
    .host_wr_data, .host_rd_req, .host_rd_data, .host_rd_valid,
    .rdy_in(rdy), .bus_request_line_n_in(1'b1),
    .bus_request_line_n_out(), .bus_request_line_n_oe(req_oe),
    .bus_grant_line_n_in(grant_n), .interrupt_or_pulse_output_n_out(),
    .interrupt_or_pulse_output_n_oe(pulse), .cyc_valid, .cyc_write,
    .cyc_addr, .cyc_wdata, .cyc_done, .cyc_rdata, .enabled,
    .end_found, .match_found);
  dma_mem_model mem (.clk, .rst_n, .req_oe, .cyc_valid, .cyc_addr,
    .grant_n, .cyc_done, .cyc_rdata);
  task automatic chk(input logic [23:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b[$]);
    foreach (b[i]) begin
      host_wr_valid <= 1'b1;
      host_wr_data <= b[i];
      @(posedge clk);
    end
    host_wr_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(output logic [7:0] v);
    host_rd_req <= 1'b1;
    @(posedge clk);
    host_rd_req <= 1'b0;
    #1 v = host_rd_data;
    chk(24'(host_rd_valid), 24'h1);
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (pulse === 1'b1) pulses++;
    if (cyc_valid && cyc_done && cyc_write) wq.push_back({cyc_addr, cyc_wdata});
    if (cyc_n == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    rst_n = 1'b0;
    host_wr_valid = 1'b0;
    host_rd_req = 1'b0;
    rdy = 1'b0;
    host_wr_data = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(d);
    chk(24'(d & 8'h1f), 24'h0);
    $display("reset test done");
    // Port A 0x2010, length 3, port B 0x3000, pulse at 2, load, go
    wr('{8'hf8, 8'h10, 8'h20, 8'h03, 8'h00, 8'h3c, 8'h00, 8'h30, 8'h02,
      8'h85, 8'h16, 8'h46, 8'h26});
    repeat (3000) if (end_found !== 1'b1) @(posedge clk);
    chk(24'(end_found), 24'h1);
    chk(24'(wq.size()), 24'h4);
    for (int i = 0; i < 4 && i < wq.size(); i++)
      chk(wq[i], {16'h3000 + 16'(i), 8'h10 + 8'(i)});
    chk(24'(pulses), 24'h1);
    $display("block test done");
    wr('{8'h0e, 8'h02, 8'h66});
    rd(d);
    chk(24'(d), 24'h3);
    rd(d);
    chk(24'(d), 24'h3);
    wr('{8'h76});
    rd(d);
    chk(24'(d & 8'h1c), 24'h4);
    $display("read test done");
    // Stop on match of 0x12: the matched third byte is the last written
    wr('{8'h1b, 8'hb1, 8'h12, 8'h16, 8'h26});
    repeat (3000) if (match_found !== 1'b1) @(posedge clk);
    chk(24'(match_found), 24'h1);
    chk(24'(end_found), 24'h0);
    chk(24'(enabled), 24'h0);
    chk(24'(wq.size()), 24'h7);
    chk(wq[6], 24'h300212);
    chk(24'(pulses), 24'h2);
    $display("match test done");
    // Without forced ready the ready pin alone gates the request
    wr('{8'h36, 8'h16, 8'h26});
    repeat (20) @(posedge clk);
    chk(24'(req_oe), 24'h0);
    rdy <= 1'b1;
    repeat (10) @(posedge clk);
    chk(24'(req_oe), 24'h1);
    repeat (3000) if (match_found !== 1'b1) @(posedge clk);
    chk(24'(wq.size()), 24'ha);
    chk(24'(pulses), 24'h3);
    rdy <= 1'b0;
    $display("ready test done");
    summarize();
  end
endmodule
